/* File: tegs_pkg.sv */
// Package holding the register map, field layout and types of the sequencer.
package tegs_pkg;

  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 32;
  localparam int          RES_W         = 16;
  localparam int          NUM_EMIT      = 3;

  // Word addresses on the Avalon-MM slave.
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_TRIG     = 4'h1;
  localparam logic [3:0]  ADDR_FLAG     = 4'h2;
  localparam logic [3:0]  ADDR_STATUS   = 4'h3;
  localparam logic [3:0]  ADDR_INT_CLR  = 4'h4;
  localparam logic [3:0]  ADDR_INT_EN   = 4'h5;
  localparam logic [3:0]  ADDR_RES0     = 4'h6;
  localparam logic [3:0]  ADDR_RES1     = 4'h7;
  localparam logic [3:0]  ADDR_RES2     = 4'h8;

  // Control register fields.
  localparam int          CTRL_SEL_LSB  = 0;
  localparam int          CTRL_GEST     = 2;
  localparam int          CTRL_SSHOT    = 3;
  localparam int          CTRL_GINT     = 4;
  localparam int          CTRL_LOGIC    = 5;
  localparam int          CTRL_W        = 6;
  localparam logic [5:0]  CTRL_RST      = 6'h00;

  // Trigger register bit.
  localparam int          TRIG_BIT      = 0;

  // Event bits of the flag and interrupt registers.
  localparam int          EV_READY      = 0;
  localparam int          EV_SINGLE     = 1;
  localparam int          EV_W          = 2;
  localparam logic [1:0]  EV_ZERO       = 2'h0;

  localparam logic [1:0]  SEL_NONE      = 2'h0;
  localparam logic [15:0] RES_ZERO      = 16'h0000;
  localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

  // Gray coded along idle, one, two, three.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EMIT1 = 2'b01,
    ST_EMIT2 = 2'b11,
    ST_EMIT3 = 2'b10
  } tegs_state_t;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
  } tegs_bus_req_t;

  typedef struct packed {
    logic              valid;
    logic [RES_W-1:0]  data;
  } tegs_meas_t;

endpackage

/* File: tegs_sequencer.sv */
// Three-emitter proximity and gesture sequencer with Avalon-MM registers.
`timescale 1ns/1ps

module tegs_sequencer
  import tegs_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [DATA_W-1:0] avs_writedata_i,
  output logic      [DATA_W-1:0] avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic                   emitter_one_o,
  output logic                   emitter_two_o,
  output logic                   emitter_three_o,
  output logic                   meas_start_o,
  input  wire logic              meas_done_i,
  input  wire logic [RES_W-1:0]  meas_data_i,
  output logic                   alert_n_o,
  output logic                   irq_o
);

  tegs_bus_req_t    req;
  tegs_meas_t       meas;
  tegs_state_t      state_reg;
  tegs_state_t      state_next;
  logic [CTRL_W-1:0] ctrl_reg;
  logic              trig_reg;
  logic [EV_W-1:0]   flag_reg;
  logic [EV_W-1:0]   status_reg;
  logic [EV_W-1:0]   int_en_reg;
  logic [RES_W-1:0]  res_reg [NUM_EMIT];
  logic              ack_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic              alert_n_reg;
  logic              irq_reg;
  logic              busy_reg;
  logic [1:0]        single_sel_reg;
  logic              done_q1;
  logic              done_q2;
  logic              done_q3;
  logic [RES_W-1:0]  data_q1;
  logic [RES_W-1:0]  data_q2;

  assign req.read      = avs_read_i;
  assign req.write     = avs_write_i;
  assign req.address   = avs_address_i;
  assign req.writedata = avs_writedata_i;

  // Measurement handshake from the analog front end crosses domains.
  // The done level passes two flops and the third gives its rising edge.
  // The data bus follows through the same two stages; the front end holds
  // it steady while done is high, so both agree once the edge is seen.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      done_q1 <= 1'b0;
      done_q2 <= 1'b0;
      done_q3 <= 1'b0;
      data_q1 <= RES_ZERO;
      data_q2 <= RES_ZERO;
    end else begin
      done_q1 <= meas_done_i;
      done_q2 <= done_q1;
      done_q3 <= done_q2;
      data_q1 <= meas_data_i;
      data_q2 <= data_q1;
    end
  end

  assign meas.valid = done_q2 & ~done_q3;
  assign meas.data  = data_q2;

  // One wait state per access keeps read data registered.
  // A master that drops its request during the wait state loses only that
  // access: nothing is taken unless the request still stands at the edge.
  wire access     = req.read | req.write;
  wire take       = access & ack_reg;
  wire wr_take    = take & req.write;
  wire rd_take    = take & req.read;
  wire wr_ctrl    = wr_take && (req.address == ADDR_CTRL);
  wire wr_trig    = wr_take && (req.address == ADDR_TRIG);
  wire wr_int_clr = wr_take && (req.address == ADDR_INT_CLR);
  wire wr_int_en  = wr_take && (req.address == ADDR_INT_EN);
  wire rd_flag    = rd_take && (req.address == ADDR_FLAG);

  assign avs_waitrequest_o = access & ~ack_reg;

  wire [1:0] sel      = ctrl_reg[CTRL_SEL_LSB +: 2];
  wire gest_en        = ctrl_reg[CTRL_GEST];
  wire sshot          = ctrl_reg[CTRL_SSHOT];
  wire gint_en        = ctrl_reg[CTRL_GINT];
  wire logic_mode     = ctrl_reg[CTRL_LOGIC];
  wire idle           = (state_reg == ST_IDLE) && !busy_reg;
  // Sweep only when both gesture and single-shot are on.
  wire sweep_go       = idle && trig_reg && gest_en && sshot;
  // Ordinary shot of the selected emitter; selection 0 means none.
  wire single_go      = idle && trig_reg && !gest_en && sshot
                        && (sel != SEL_NONE);
  // Free-running ordinary mode when single-shot and gesture are both off.
  wire free_go        = idle && !sshot && !gest_en
                        && (sel != SEL_NONE);
  wire sweep_done     = (state_reg == ST_EMIT3) && meas.valid;

  wire [EV_W-1:0] ev_set;
  assign ev_set[EV_READY]  = sweep_done;
  assign ev_set[EV_SINGLE] = busy_reg && meas.valid;

  // The sweep steps on each synchronised result. A trigger written while a
  // sweep runs waits in its bit and starts the next sweep once idle.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  if (sweep_go) state_next = ST_EMIT1;
      ST_EMIT1: if (meas.valid) state_next = ST_EMIT2;
      ST_EMIT2: if (meas.valid) state_next = ST_EMIT3;
      ST_EMIT3: if (meas.valid) state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Ordinary single measurement tracking.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      busy_reg       <= 1'b0;
      single_sel_reg <= SEL_NONE;
    end else if (single_go || free_go) begin
      busy_reg       <= 1'b1;
      single_sel_reg <= sel;
    end else if (meas.valid) begin
      busy_reg       <= 1'b0;
    end
  end

  // The emitter must already shine in the cycle of the start pulse, so the
  // drive looks at the next busy state rather than the registered one.
  wire       single_start = single_go || free_go;
  wire       busy_next    = single_start || (busy_reg && !meas.valid);
  wire [1:0] sel_next     = single_start ? sel : single_sel_reg;

  // Emitter drive follows the sweep step or the single selection.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      emitter_one_o   <= 1'b0;
      emitter_two_o   <= 1'b0;
      emitter_three_o <= 1'b0;
      meas_start_o    <= 1'b0;
    end else begin
      emitter_one_o   <= (state_next == ST_EMIT1) ||
                         (busy_next && sel_next == 2'h1);
      emitter_two_o   <= (state_next == ST_EMIT2) ||
                         (busy_next && sel_next == 2'h2);
      emitter_three_o <= (state_next == ST_EMIT3) ||
                         (busy_next && sel_next == 2'h3);
      meas_start_o    <= sweep_go || single_go || free_go ||
                         ((state_reg != ST_EMIT3) &&
                          (state_reg != ST_IDLE) && meas.valid);
    end
  end

  // Results: the sweep writes channels in order, a single shot its own.
  // Each channel keeps its last result until the next hit on it.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EMIT; gi++) begin : g_res
      localparam logic [1:0] STEP_SEL = 2'(gi + 1);
      wire sweep_hit = meas.valid &&
        ((gi == 0 && state_reg == ST_EMIT1) ||
         (gi == 1 && state_reg == ST_EMIT2) ||
         (gi == 2 && state_reg == ST_EMIT3));
      wire single_hit = meas.valid && busy_reg &&
                        (single_sel_reg == STEP_SEL);
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          res_reg[gi] <= RES_ZERO;
        end else if (sweep_hit || single_hit) begin
          res_reg[gi] <= meas.data;
        end
      end
    end
  endgenerate

  // Control and trigger; trigger drops as soon as its work begins.
  // Writes to unmapped words fall through every decode and are dropped.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST;
      trig_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= req.writedata[CTRL_W-1:0];
      end
      if (sweep_go || single_go) begin
        trig_reg <= 1'b0;
      end else if (wr_trig) begin
        trig_reg <= req.writedata[TRIG_BIT];
      end
    end
  end

  // The ready flag only counts when the gesture interrupt is enabled.
  wire [EV_W-1:0] flag_set;
  assign flag_set[EV_READY]  = ev_set[EV_READY] & gint_en;
  assign flag_set[EV_SINGLE] = ev_set[EV_SINGLE];

  // Only the bits that the host has just been shown are cleared, so an
  // event that lands during the read's wait state stays for the next read.
  wire [EV_W-1:0] flag_clr   = rd_flag ? rdata_reg[EV_W-1:0] : EV_ZERO;
  wire [EV_W-1:0] status_clr = wr_int_clr ? req.writedata[EV_W-1:0]
                                          : EV_ZERO;

  // Set wins over a clear in the same cycle, so no event is lost.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flag_reg   <= EV_ZERO;
      status_reg <= EV_ZERO;
      int_en_reg <= EV_ZERO;
    end else begin
      flag_reg   <= (flag_reg & ~flag_clr) | flag_set;
      status_reg <= (status_reg & ~status_clr) | ev_set;
      if (wr_int_en) begin
        int_en_reg <= req.writedata[EV_W-1:0];
      end
    end
  end

  // In logic output mode the alert pin shows the last ready state only.
  // That trades the full flag view for a pin that tracks the sweep alone.
  wire alert_now = logic_mode ? flag_reg[EV_READY] : (|flag_reg);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      alert_n_reg <= 1'b1;
      irq_reg     <= 1'b0;
    end else begin
      alert_n_reg <= ~alert_now;
      // The interrupt is a level: it falls once every enabled bit is clear.
      irq_reg     <= |(status_reg & int_en_reg);
    end
  end

  assign alert_n_o = alert_n_reg;
  assign irq_o     = irq_reg;

  // Read select; the flag register reads its value before the clear.
  // Unmapped words and the write-only clear word read as zero.
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = RD_ZERO;
    if (req.address == ADDR_CTRL) begin
      rd_mux = DATA_W'(ctrl_reg);
    end else if (req.address == ADDR_TRIG) begin
      rd_mux = DATA_W'(trig_reg);
    end else if (req.address == ADDR_FLAG) begin
      rd_mux = DATA_W'(flag_reg);
    end else if (req.address == ADDR_STATUS) begin
      rd_mux = DATA_W'(status_reg);
    end else if (req.address == ADDR_INT_EN) begin
      rd_mux = DATA_W'(int_en_reg);
    end else if (req.address == ADDR_RES0) begin
      rd_mux = DATA_W'(res_reg[0]);
    end else if (req.address == ADDR_RES1) begin
      rd_mux = DATA_W'(res_reg[1]);
    end else if (req.address == ADDR_RES2) begin
      rd_mux = DATA_W'(res_reg[2]);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= RD_ZERO;
    end else begin
      ack_reg   <= access & ~ack_reg;
      rdata_reg <= rd_mux;
    end
  end

  assign avs_readdata_o = rdata_reg;

endmodule

/* File: tegs_monitor.sv */
// Port checker for the three-emitter gesture sequencer.
`timescale 1ns/1ps
module tegs_monitor
  import tegs_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              rst_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic              avs_read_i,
  input wire logic              avs_write_i,
  input wire logic [DATA_W-1:0] avs_writedata_i,
  input wire logic [DATA_W-1:0] avs_readdata_o,
  input wire logic              avs_waitrequest_o,
  input wire logic              emitter_one_o,
  input wire logic              emitter_two_o,
  input wire logic              emitter_three_o,
  input wire logic              meas_start_o,
  input wire logic              meas_done_i,
  input wire logic [RES_W-1:0]  meas_data_i,
  input wire logic              alert_n_o,
  input wire logic              irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire       rq  = avs_read_i | avs_write_i;
  wire       rtk = avs_read_i & !avs_waitrequest_o;
  wire [2:0] em  = {emitter_three_o, emitter_two_o, emitter_one_o};
  chk_wait_first: assert property ($rose(rq) |-> avs_waitrequest_o)
    else $error("access answered in its first cycle");
  chk_wait_one: assert property (rq && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("access not answered in second cycle");
  chk_emit_single: assert property ($onehot0(em))
    else $error("more than one emitter on");
  chk_start_emit: assert property (meas_start_o |-> $onehot(em))
    else $error("conversion started with no emitter");
  chk_start_pulse: assert property (meas_start_o |=> !meas_start_o)
    else $error("start pulse longer than one cycle");
  chk_flag_release: assert property (rtk && avs_address_i == ADDR_FLAG
    && !alert_n_o |-> ##[1:3] alert_n_o)
    else $error("alert not released after flag read");
  chk_unmapped_zero: assert property (rtk && avs_address_i > ADDR_RES2
    |-> avs_readdata_o == RD_ZERO)
    else $error("unmapped read not zero");
  chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
    alert_n_o && !irq_o && !meas_start_o && em == 3'h0)
    else $error("outputs not quiet after reset");
  cover property (meas_start_o && emitter_three_o);
  cover property ($fell(alert_n_o));
  cover property (rtk && avs_address_i == ADDR_FLAG);
endmodule
bind tegs_sequencer tegs_monitor u_mon (.*);

/* File: tegs_fe_model.sv */
// Behavioural model of the front end that runs one conversion per start.
`timescale 1ns/1ps
module tegs_fe_model (
  input  wire logic        mclk_i,
  input  wire logic        slow_i,
  input  wire logic        meas_start_i,
  input  wire logic [2:0]  emit_i,
  output logic             meas_done_o,
  output logic [15:0]      meas_data_o
);
  logic [7:0] cnt;
  logic [3:0] idx;
  // A running count in the data tells a stale result from a fresh one.
  initial begin
    meas_done_o = 1'b0;
    meas_data_o = 16'hFFFF;
    cnt = 8'h00;
    forever begin
      @(posedge mclk_i);
      if (meas_start_i) begin
        meas_done_o <= 1'b0;
        meas_data_o <= ~meas_data_o;
        idx = emit_i[0] ? 4'h1 : emit_i[1] ? 4'h2 : 4'h3;
        repeat (slow_i ? 12 : 4) @(posedge mclk_i);
        meas_data_o <= {4'hA, cnt, idx};
        meas_done_o <= 1'b1;
        cnt = cnt + 8'h01;
      end
    end
  end
endmodule

/* File: test_tegs_sequencer.sv */
// Self-checking bench for the gesture sequencer.
`timescale 1ns/1ps
module test_tegs_sequencer
  import tegs_pkg::*;
;
  logic              mclk_i = 1'b0, rst_i = 1'b1, slow_i = 1'b0;
  logic              avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic [DATA_W-1:0] avs_writedata_i = '0, avs_readdata_o, q;
  logic              avs_waitrequest_o, meas_start_o, meas_done_i;
  logic              emitter_one_o, emitter_two_o, emitter_three_o;
  logic              alert_n_o, irq_o;
  logic [RES_W-1:0]  meas_data_i;
  logic [2:0]        seq [0:15];
  int                n_start = 0, err_total = 0, samples_checked = 0;
  int                cycles = 0, i, s;

  tegs_sequencer u_dut (.*);
  tegs_fe_model u_fe (.mclk_i(mclk_i), .slow_i(slow_i),
    .meas_start_i(meas_start_o), .meas_done_o(meas_done_i),
    .emit_i({emitter_three_o, emitter_two_o, emitter_one_o}),
    .meas_data_o(meas_data_i));

  initial forever #50 mclk_i = ~mclk_i;

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (meas_start_o === 1'b1) begin
      seq[n_start[3:0]] = {emitter_three_o, emitter_two_o, emitter_one_o};
      n_start++;
    end
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic cmp(input string nm, input logic [31:0] v, e);
    samples_checked++;
    if (v !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, v);
    end
  endtask

  // Request held until the edge that sees waitrequest low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    cmp(nm, q, e);
  endtask

  function automatic logic [31:0] rv(input int k, input int x);
    return {16'h0, 4'hA, 8'(k), 4'(x)};
  endfunction

  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    chk("ctrl", ADDR_CTRL, 32'h0);
    chk("flag", ADDR_FLAG, 32'h0);
    chk("unmapped", 4'hF, 32'h0);
    cmp("alert", 32'(alert_n_o), 32'h1);
    bus(1'b1, ADDR_CTRL, 32'h1C);
    repeat (30) @(posedge mclk_i);
    cmp("idle starts", n_start, 0);
    bus(1'b1, ADDR_INT_EN, 32'h3);
    bus(1'b1, ADDR_TRIG, 32'h1);
    repeat (2) @(posedge mclk_i);
    chk("trig", ADDR_TRIG, 32'h0);
    for (i = 0; i < 400 && alert_n_o !== 1'b0; i++) @(posedge mclk_i);
    cmp("alert", 32'(alert_n_o), 32'h0);
    repeat (2) @(posedge mclk_i);
    cmp("irq", 32'(irq_o), 32'h1);
    cmp("sweep starts", n_start, 3);
    for (i = 0; i < 3; i++) begin
      cmp("order", 32'(seq[i]), 32'h1 << i);
      chk("result", 4'(ADDR_RES0 + i), rv(i, i + 1));
    end
    chk("status", ADDR_STATUS, 32'h1);
    chk("flag", ADDR_FLAG, 32'h1);
    chk("flag cleared", ADDR_FLAG, 32'h0);
    repeat (2) @(posedge mclk_i);
    cmp("alert back", 32'(alert_n_o), 32'h1);
    bus(1'b1, ADDR_INT_CLR, 32'h3);
    repeat (3) @(posedge mclk_i);
    cmp("irq cleared", 32'(irq_o), 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h14);
    bus(1'b1, ADDR_TRIG, 32'h1);
    repeat (30) @(posedge mclk_i);
    cmp("no sweep", n_start, 3);
    bus(1'b1, ADDR_TRIG, 32'h0);
    slow_i <= 1'b1;
    for (s = 1; s < 4; s++) begin
      bus(1'b1, ADDR_CTRL, 32'h8 | s);
      bus(1'b1, ADDR_TRIG, 32'h1);
      for (i = 0; i < 40; i++) begin
        bus(1'b0, ADDR_STATUS, '0);
        if (q[1] === 1'b1) break;
      end
      cmp("emitter", 32'(seq[s + 2]), 32'h1 << (s - 1));
      chk("single", 4'(ADDR_RES0 + s - 1), rv(s + 2, s));
      chk("flag", ADDR_FLAG, 32'h2);
      bus(1'b1, ADDR_INT_CLR, 32'h3);
    end
    bus(1'b1, ADDR_CTRL, 32'h29);
    bus(1'b1, ADDR_TRIG, 32'h1);
    repeat (40) @(posedge mclk_i);
    cmp("logic alert", 32'(alert_n_o), 32'h1);
    chk("logic result", ADDR_RES0, rv(6, 1));
    chk("logic flag", ADDR_FLAG, 32'h2);
    repeat (30) @(posedge mclk_i);
    cmp("total starts", n_start, 7);
    give_verdict();
  end
endmodule
